// File: design/keypad_command_selector.sv
// Function
// [RULE1] up/down edit PID command: PID on, remote source 0, monitor nonzero, running
// [RULE2] programming or alarm mode blocks PID command edits
// [RULE3] edited PID command is kept in the retained store
// [RULE4] multistep bit four does not block keypad PID command edits
// [RULE5] nonzero PID remote source: keys only show the command
// [RULE6] decimal point blinks for PID command, steady for feedback
// [RULE7] under PID, frequency edit needs source 0, plain manual, speed monitor, running
// [RULE8] plain inputs: bypass off hits PID output, on hits keypad speed
// [RULE9] other inputs: bypass off hits PID output, on views selected speed
// [RULE10] programming or alarm mode blocks frequency edits
// [RULE11] run key only in running mode; stop key decelerates to stop
// [RULE12] run source 0 terminals, 1 key off, 2 forward, 3 reverse
// [RULE13] remote mode takes sources from settings, select two and link signal
// [RULE14] local mode takes run and frequency from keypad only
// [RULE15] keypad loss during keypad-controlled run stops the motor
// [RULE16] local-select input level picks remote or local mode
// [RULE17] key presses become single-cycle events checked that cycle
//
// Implementation choices: strobed register access and the address map.
module keypad_command_selector #(
    parameter int unsigned BLINK_HALF_CYCLES = keypad_cmd_pkg::BLINK_HALF_CYCLES
) (
    input logic ref_clk,
    input logic reset,
    input logic [keypad_cmd_pkg::ADDR_W-1:0] addr,
    input logic [keypad_cmd_pkg::DATA_W-1:0] wrData,
    input logic wrStrobe,
    input logic rdStrobe,
    output logic [keypad_cmd_pkg::DATA_W-1:0] rdData,
    input keypad_cmd_pkg::keys_t keyRaw,
    input keypad_cmd_pkg::terminals_t terminalRaw,
    input keypad_cmd_pkg::keypad_mode_t keypadMode,
    input logic linkRunForward,
    input logic linkRunReverse,
    output logic runForward,
    output logic runReverse,
    output logic [keypad_cmd_pkg::CMD_W-1:0] pidCommand,
    output logic [keypad_cmd_pkg::CMD_W-1:0] freqCommand,
    output keypad_cmd_pkg::target_t keyTarget,
    output logic showPidCommand,
    output logic decimalPoint,
    output logic localMode
);
    localparam logic [keypad_cmd_pkg::BLINK_CNT_W-1:0] BLINK_LAST =
        keypad_cmd_pkg::BLINK_CNT_W'(BLINK_HALF_CYCLES - 1);

    // saturating step of a stored command, shared by both edit paths
    function automatic logic [keypad_cmd_pkg::CMD_W-1:0] stepCmd(
        input logic [keypad_cmd_pkg::CMD_W-1:0] v,
        input logic up
    );
        if (up) begin
            stepCmd = (v == keypad_cmd_pkg::CMD_MAX) ? v : v + 16'h0001;
        end else begin
            stepCmd = (v == keypad_cmd_pkg::CMD_MIN) ? v : v - 16'h0001;
        end
    endfunction

    // direction from a forward/reverse pair; both or neither means no run
    function automatic keypad_cmd_pkg::run_state_t pairDir(input logic forward_terminal, input logic reverse_terminal);
        if (forward_terminal && !reverse_terminal) begin
            pairDir = keypad_cmd_pkg::RUN_FORWARD;
        end else if (reverse_terminal && !forward_terminal) begin
            pairDir = keypad_cmd_pkg::RUN_REVERSE;
        end else begin
            pairDir = keypad_cmd_pkg::RUN_IDLE;
        end
    endfunction

    keypad_cmd_pkg::keys_t keyPress;
    keypad_cmd_pkg::terminals_t term;
    keypad_cmd_pkg::config_t cfg_q;
    keypad_cmd_pkg::target_t target_q;
    keypad_cmd_pkg::target_t targetNow;
    keypad_cmd_pkg::run_state_t runState_q;
    keypad_cmd_pkg::run_state_t runState_d;
    keypad_cmd_pkg::run_state_t keyRunDir;
    keypad_cmd_pkg::run_state_t linkDir;
    keypad_cmd_pkg::status_t status;
    logic [keypad_cmd_pkg::DATA_W-1:0] rdData_q;
    logic [keypad_cmd_pkg::DATA_W-1:0] rdNext;
    logic [keypad_cmd_pkg::CMD_W-1:0] newPid;
    logic [keypad_cmd_pkg::CMD_W-1:0] newFreq;
    logic [keypad_cmd_pkg::CMD_W-1:0] storeData;
    logic [keypad_cmd_pkg::BLINK_CNT_W-1:0] blinkCnt_q;
    logic [1:0] remoteRunSrc;
    logic [1:0] localRunSrc;
    logic [1:0] runSrc;
    logic blinkPhase_q, decimalPoint_q, showCmd_q, local_q, runFwd_q, runRev_q;
    logic wrConfig, wrPid, wrFreq, swWrite;
    logic pidOn, running, monSpeed, manualPlain, freqKeypadSrc, pidKeypadSrc;
    logic keyUpDown, keyIsUp, pidWrite, freqWrite, storeWe, storeAddr;
    logic linkDrives, terminalDrives, keypadCtl, runKeyOk, stopReq;
    logic dpBlink, dpSteady;

    // keys become one-cycle events; terminals are levels
    key_event_sync #(.W($bits(keypad_cmd_pkg::keys_t))) keySync (
        .ref_clk(ref_clk),
        .reset(reset),
        .rawIn(keyRaw),
        .levelQ(),
        .riseQ(keyPress) // RULE17
    );

    key_event_sync #(.W($bits(keypad_cmd_pkg::terminals_t))) termSync (
        .ref_clk(ref_clk),
        .reset(reset),
        .rawIn(terminalRaw),
        .levelQ(term),
        .riseQ()
    );

    // register port decode
    assign wrConfig = wrStrobe && (addr == keypad_cmd_pkg::ADDR_CONFIG);
    assign wrPid = wrStrobe && (addr == keypad_cmd_pkg::ADDR_PID_CMD);
    assign wrFreq = wrStrobe && (addr == keypad_cmd_pkg::ADDR_FREQ_CMD);
    assign swWrite = wrPid || wrFreq;

    // selection conditions evaluated in the cycle of the press
    assign pidOn = (cfg_q.pidControlSelect == keypad_cmd_pkg::PID_SEL_PROCESS)
        || (cfg_q.pidControlSelect == keypad_cmd_pkg::PID_SEL_INVERSE);
    assign running = (keypadMode == keypad_cmd_pkg::MODE_RUNNING); // RULE2 RULE10
    assign monSpeed = (cfg_q.displayMonitorSelect == keypad_cmd_pkg::MON_SPEED);
    assign manualPlain = !term.multistepBitOne && !term.multistepBitTwo
        && !term.linkOperationSelect;
    // local mode makes the keypad the frequency source regardless of settings
    assign freqKeypadSrc = local_q // RULE14
        || ((cfg_q.freqCmd1Source == keypad_cmd_pkg::FREQ_SRC_KEYPAD) && manualPlain); // RULE7
    // multistep bit four is deliberately absent here
    assign pidKeypadSrc = (cfg_q.pidRemoteCmdSource == keypad_cmd_pkg::PID_REMOTE_KEYPAD); // RULE4

    // what the up/down keys address
    assign targetNow = (pidOn && !monSpeed) ?
        (pidKeypadSrc ? keypad_cmd_pkg::TGT_PID_CMD_EDIT : keypad_cmd_pkg::TGT_PID_CMD_VIEW) :
        (pidOn && !term.pidBypass) ? keypad_cmd_pkg::TGT_PID_OUTPUT : // RULE8 RULE9
        (freqKeypadSrc ? keypad_cmd_pkg::TGT_FREQ_EDIT : keypad_cmd_pkg::TGT_FREQ_VIEW);

    // both keys at once cancel out rather than picking one
    assign keyUpDown = keyPress.keyUp ^ keyPress.keyDown;
    assign keyIsUp = keyPress.keyUp;
    assign pidWrite = keyUpDown && running
        && (targetNow == keypad_cmd_pkg::TGT_PID_CMD_EDIT); // RULE1
    assign freqWrite = keyUpDown && running
        && (targetNow == keypad_cmd_pkg::TGT_FREQ_EDIT); // RULE7
    assign newPid = stepCmd(pidCommand, keyIsUp);
    assign newFreq = stepCmd(freqCommand, keyIsUp);

    // store port: software writes win over a key edit in the same cycle
    assign storeWe = swWrite || pidWrite || freqWrite; // RULE3
    assign storeAddr = wrFreq || (!wrPid && freqWrite);
    assign storeData = swWrite ? wrData[keypad_cmd_pkg::CMD_W-1:0] :
        (freqWrite ? newFreq : newPid);

    cmd_store store (
        .ref_clk(ref_clk),
        .reset(reset),
        .writeEn(storeWe),
        .writeAddr(storeAddr),
        .writeData(storeData),
        .pidValue(pidCommand),
        .freqValue(freqCommand)
    );

    // run source selection for remote and local modes
    assign remoteRunSrc = term.runCmdSelect2 ? cfg_q.runCmd2Source : cfg_q.runCmdSource; // RULE13
    assign localRunSrc = (cfg_q.runCmdSource == keypad_cmd_pkg::RUN_SRC_TERMINAL) ?
        keypad_cmd_pkg::RUN_SRC_FORWARD : cfg_q.runCmdSource; // RULE14
    assign runSrc = local_q ? localRunSrc : remoteRunSrc;
    assign linkDrives = !local_q && term.linkOperationSelect; // RULE13
    assign terminalDrives = !linkDrives && (runSrc == keypad_cmd_pkg::RUN_SRC_TERMINAL);
    assign keypadCtl = !linkDrives && !terminalDrives;
    assign linkDir = pairDir(linkRunForward, linkRunReverse);
    assign runKeyOk = keyPress.keyRun && running && keypadCtl; // RULE11
    assign stopReq = keyPress.keyStop || !term.keypadPresent; // RULE11 RULE15

    // direction chosen by the run key
    always_comb begin
        unique case (runSrc)
            keypad_cmd_pkg::RUN_SRC_FORWARD: keyRunDir = keypad_cmd_pkg::RUN_FORWARD;
            keypad_cmd_pkg::RUN_SRC_REVERSE: keyRunDir = keypad_cmd_pkg::RUN_REVERSE;
            keypad_cmd_pkg::RUN_SRC_TERM_DIR: begin
                keyRunDir = pairDir(term.forwardTerminal, term.reverseTerminal); // RULE12
            end
            keypad_cmd_pkg::RUN_SRC_TERMINAL: keyRunDir = keypad_cmd_pkg::RUN_IDLE; // RULE12
        endcase
    end

    // run state: link and terminals drive directly, the keypad latches
    always_comb begin
        runState_d = runState_q;
        if (linkDrives) begin
            runState_d = linkDir; // RULE13
        end else if (terminalDrives) begin
            runState_d = pairDir(term.forwardTerminal, term.reverseTerminal); // RULE12
        end else if (stopReq) begin
            runState_d = keypad_cmd_pkg::RUN_IDLE; // RULE15
        end else if (runKeyOk) begin
            runState_d = keyRunDir; // RULE12
        end
    end

    // decimal point: blink for PID command or output, steady for feedback
    assign dpBlink = showCmd_q
        || (cfg_q.displayMonitorSelect == keypad_cmd_pkg::MON_PID_CMD)
        || (cfg_q.displayMonitorSelect == keypad_cmd_pkg::MON_PID_OUTPUT);
    assign dpSteady = (cfg_q.displayMonitorSelect == keypad_cmd_pkg::MON_PID_FEEDBACK);

    // status word and read mux; unmapped reads give zero
    assign status = '{decimalPoint: decimalPoint_q, keyTarget: target_q,
        localMode: local_q, runForward: runFwd_q, runReverse: runRev_q,
        showPidCommand: showCmd_q, keypadPresent: term.keypadPresent};
    assign rdNext =
        (addr == keypad_cmd_pkg::ADDR_CONFIG) ? {16'h0000, cfg_q} :
        (addr == keypad_cmd_pkg::ADDR_PID_CMD) ? {16'h0000, pidCommand} :
        (addr == keypad_cmd_pkg::ADDR_FREQ_CMD) ? {16'h0000, freqCommand} :
        (addr == keypad_cmd_pkg::ADDR_STATUS) ? {23'h000000, status} :
        32'h00000000;

    // register port and settings
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cfg_q <= keypad_cmd_pkg::CONFIG_RESET;
            rdData_q <= 32'h00000000;
        end else begin
            cfg_q <= wrConfig ? keypad_cmd_pkg::config_t'(wrData[15:0]) : cfg_q;
            rdData_q <= rdStrobe ? rdNext : 32'h00000000;
        end
    end

    // key target and command view; a settings write drops the view unless a key press shows it in the same cycle
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            target_q <= keypad_cmd_pkg::TGT_FREQ_VIEW;
            showCmd_q <= 1'b0;
            local_q <= 1'b0;
        end else begin
            target_q <= targetNow;
            local_q <= term.localModeSelect; // RULE16
            if (keyUpDown && (targetNow == keypad_cmd_pkg::TGT_PID_CMD_VIEW
                || targetNow == keypad_cmd_pkg::TGT_PID_CMD_EDIT)) begin
                showCmd_q <= 1'b1; // RULE5
            end else if (wrConfig) begin
                showCmd_q <= 1'b0;
            end
        end
    end

    // blink timebase, free running so every blinking display is in phase
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            blinkCnt_q <= '0;
            blinkPhase_q <= 1'b0;
            decimalPoint_q <= 1'b0;
        end else begin
            blinkCnt_q <= (blinkCnt_q == BLINK_LAST) ? '0 : blinkCnt_q + 24'h000001;
            blinkPhase_q <= (blinkCnt_q == BLINK_LAST) ? !blinkPhase_q : blinkPhase_q;
            decimalPoint_q <= dpBlink ? blinkPhase_q : dpSteady; // RULE6
        end
    end

    // run state and direction outputs
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            runState_q <= keypad_cmd_pkg::RUN_IDLE;
            runFwd_q <= 1'b0;
            runRev_q <= 1'b0;
        end else begin
            runState_q <= runState_d;
            runFwd_q <= (runState_d == keypad_cmd_pkg::RUN_FORWARD);
            runRev_q <= (runState_d == keypad_cmd_pkg::RUN_REVERSE);
        end
    end

    assign rdData = rdData_q;
    assign runForward = runFwd_q;
    assign runReverse = runRev_q;
    assign keyTarget = target_q;
    assign showPidCommand = showCmd_q;
    assign decimalPoint = decimalPoint_q;
    assign localMode = local_q;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    pid_edit_gate_a: assert property (pidWrite |-> pidOn && pidKeypadSrc // RULE1
        && !monSpeed && running) else $error("pid edit outside its conditions");
    pid_mode_block_a: assert property (!running |-> !pidWrite) // RULE2
        else $error("pid edit outside running mode");
    pid_store_a: assert property ((pidWrite && !swWrite) ##1 !storeWe // RULE3
        |-> ##1 pidCommand == $past(newPid, 2)) else $error("pid edit not stored");
    ss4_free_a: assert property ((keyUpDown && running && pidOn && pidKeypadSrc // RULE4
        && !monSpeed && term.multistepBitFour) |-> pidWrite)
        else $error("multistep four blocked pid edit");
    pid_view_hold_a: assert property ((keyUpDown && !swWrite // RULE5
        && targetNow == keypad_cmd_pkg::TGT_PID_CMD_VIEW) ##1 !swWrite && !wrConfig
        |=> $stable(pidCommand) && showCmd_q) else $error("viewed pid command changed");
    dp_steady_a: assert property ((dpSteady && !showCmd_q)[*2] |-> decimalPoint_q) // RULE6
        else $error("feedback decimal point not steady");
    freq_edit_gate_a: assert property (freqWrite |-> running && freqKeypadSrc // RULE7
        && (!pidOn || (monSpeed && term.pidBypass))) else $error("frequency edit misgated");
    freq_mode_block_a: assert property (!running |-> !freqWrite) // RULE10
        else $error("frequency edit outside running mode");
    pid_output_tgt_a: assert property ((pidOn && monSpeed && !term.pidBypass) // RULE8
        |=> keyTarget == keypad_cmd_pkg::TGT_PID_OUTPUT) else $error("keys miss pid output");
    bypass_view_a: assert property ((pidOn && monSpeed && term.pidBypass && !local_q // RULE9
        && !manualPlain) |=> keyTarget == keypad_cmd_pkg::TGT_FREQ_VIEW)
        else $error("bypass did not select current speed");
    run_mode_a: assert property ((keypadCtl && !running && !keyPress.keyStop // RULE11
        && runState_q == keypad_cmd_pkg::RUN_IDLE) |=> runState_q == keypad_cmd_pkg::RUN_IDLE)
        else $error("run key honoured outside running mode");
    run_reverse_a: assert property ((runKeyOk && !stopReq // RULE12
        && runSrc == keypad_cmd_pkg::RUN_SRC_REVERSE) |=> runReverse && !runForward)
        else $error("reverse source did not run reverse");
    link_run_a: assert property (linkDrives |=> runState_q == $past(linkDir)) // RULE13
        else $error("link operation not followed");
    local_run_a: assert property ((local_q && runKeyOk && !stopReq // RULE14
        && cfg_q.runCmdSource == keypad_cmd_pkg::RUN_SRC_TERMINAL)
        |=> runState_q == keypad_cmd_pkg::RUN_FORWARD) else $error("local run key ignored");
    keypad_loss_a: assert property ((keypadCtl && !term.keypadPresent) // RULE15
        |=> !runForward && !runReverse) else $error("keypad loss did not stop");
    local_follow_a: assert property (term.localModeSelect |=> localMode) // RULE16
        else $error("local mode not following input");
    press_single_a: assert property (keyPress.keyUp |=> !keyPress.keyUp) // RULE17
        else $error("key press longer than one cycle");

    pid_edit_c: cover property (pidWrite && term.multistepBitFour);
    freq_edit_c: cover property (freqWrite && pidOn);
    run_fwd_c: cover property ($rose(runForward));
    loss_stop_c: cover property (keypadCtl && !term.keypadPresent && runState_q != 2'h0);
endmodule // keypad_command_selector

// File: shared/keypad_cmd_pkg.sv
package keypad_cmd_pkg;
    // register port geometry
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned CMD_W = 16;
    localparam int unsigned CFG_W = 16;

    // register byte addresses
    localparam logic [ADDR_W-1:0] ADDR_CONFIG = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_PID_CMD = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_FREQ_CMD = 4'h8;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'hc;

    // setting encodings
    localparam logic [1:0] PID_SEL_PROCESS = 2'h1;
    localparam logic [1:0] PID_SEL_INVERSE = 2'h2;
    localparam logic [1:0] PID_REMOTE_KEYPAD = 2'h0;
    localparam logic [4:0] MON_SPEED = 5'h00;
    localparam logic [4:0] MON_PID_CMD = 5'h0a;
    localparam logic [4:0] MON_PID_FEEDBACK = 5'h0c;
    localparam logic [4:0] MON_PID_OUTPUT = 5'h0e;
    localparam logic [2:0] FREQ_SRC_KEYPAD = 3'h0;
    localparam logic [1:0] RUN_SRC_TERM_DIR = 2'h0;
    localparam logic [1:0] RUN_SRC_TERMINAL = 2'h1;
    localparam logic [1:0] RUN_SRC_FORWARD = 2'h2;
    localparam logic [1:0] RUN_SRC_REVERSE = 2'h3;

    // command store slots and limits
    localparam logic STORE_PID = 1'b0;
    localparam logic STORE_FREQ = 1'b1;
    localparam logic [CMD_W-1:0] CMD_MAX = 16'hffff;
    localparam logic [CMD_W-1:0] CMD_MIN = 16'h0000;

    // decimal point blink timing
    localparam longint unsigned CLK_HZ = 40_000_000;
    localparam longint unsigned BLINK_HALF_MS = 250;
    localparam int unsigned BLINK_HALF_CYCLES = int'(CLK_HZ / 1000 * BLINK_HALF_MS);
    localparam int unsigned BLINK_CNT_W = 24;

    typedef struct packed {
        logic [1:0] runCmd2Source;
        logic [1:0] runCmdSource;
        logic [2:0] freqCmd1Source;
        logic [4:0] displayMonitorSelect;
        logic [1:0] pidRemoteCmdSource;
        logic [1:0] pidControlSelect;
    } config_t;
    localparam config_t CONFIG_RESET = 16'ha000;

    typedef struct packed {
        logic keyUp;
        logic keyDown;
        logic keyRun;
        logic keyStop;
    } keys_t;

    typedef struct packed {
        logic keypadPresent;
        logic forwardTerminal;
        logic reverseTerminal;
        logic multistepBitOne;
        logic multistepBitTwo;
        logic multistepBitFour;
        logic linkOperationSelect;
        logic pidBypass;
        logic localModeSelect;
        logic runCmdSelect2;
    } terminals_t;

    typedef enum logic [1:0] {
        MODE_RUNNING = 2'h0,
        MODE_PROGRAMMING = 2'h1,
        MODE_ALARM = 2'h3
    } keypad_mode_t;

    typedef enum logic [2:0] {
        TGT_PID_CMD_EDIT = 3'h0,
        TGT_PID_CMD_VIEW = 3'h1,
        TGT_PID_OUTPUT = 3'h3,
        TGT_FREQ_EDIT = 3'h2,
        TGT_FREQ_VIEW = 3'h6
    } target_t;

    typedef enum logic [1:0] {
        RUN_IDLE = 2'h0,
        RUN_FORWARD = 2'h1,
        RUN_REVERSE = 2'h2
    } run_state_t;

    typedef struct packed {
        logic decimalPoint;
        target_t keyTarget;
        logic localMode;
        logic runForward;
        logic runReverse;
        logic showPidCommand;
        logic keypadPresent;
    } status_t;
endpackage

// File: design/key_event_sync.sv
module key_event_sync #(
    parameter int unsigned W = 4
) (
    input logic ref_clk,
    input logic reset,
    input logic [W-1:0] rawIn,
    output logic [W-1:0] levelQ,
    output logic [W-1:0] riseQ
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;
    logic [W-1:0] prev_q;
    logic [W-1:0] rise_q;

    // two flops before use; only sync_q feeds the edge logic
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
            rise_q <= '0;
        end else begin
            meta_q <= rawIn;
            sync_q <= meta_q;
            prev_q <= sync_q;
            rise_q <= sync_q & ~prev_q; // one pulse per press
        end
    end

    assign levelQ = sync_q;
    assign riseQ = rise_q;
endmodule // key_event_sync

// File: design/cmd_store.sv
module cmd_store (
    input logic ref_clk,
    input logic reset,
    input logic writeEn,
    input logic writeAddr,
    input logic [keypad_cmd_pkg::CMD_W-1:0] writeData,
    output logic [keypad_cmd_pkg::CMD_W-1:0] pidValue,
    output logic [keypad_cmd_pkg::CMD_W-1:0] freqValue
);
    logic [keypad_cmd_pkg::CMD_W-1:0] mem [2];
    logic [keypad_cmd_pkg::CMD_W-1:0] pidRd_q;
    logic [keypad_cmd_pkg::CMD_W-1:0] freqRd_q;

    // contents are retained across reset, standing in for the retained store
    always_ff @(posedge ref_clk) begin
        if (writeEn) begin
            mem[writeAddr] <= writeData;
        end
    end

    // registered read ports, one cycle behind the array
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pidRd_q <= keypad_cmd_pkg::CMD_MIN;
            freqRd_q <= keypad_cmd_pkg::CMD_MIN;
        end else begin
            pidRd_q <= mem[keypad_cmd_pkg::STORE_PID];
            freqRd_q <= mem[keypad_cmd_pkg::STORE_FREQ];
        end
    end

    assign pidValue = pidRd_q;
    assign freqValue = freqRd_q;
endmodule // cmd_store

// File: verification/keypad_partner.sv
module keypad_partner (
    input wire logic ref_clk,
    output keypad_cmd_pkg::keys_t keyRaw,
    output keypad_cmd_pkg::terminals_t terminalRaw
);
    timeunit 1ns;
    timeprecision 1ps;
    // keypad attached, every terminal off
    initial begin
        keyRaw = '0;
        terminalRaw = '0;
        terminalRaw.keypadPresent = 1'b1;
    end
    // held long enough for the synchroniser, released before the next press
    task automatic press(input int idx);
        @(posedge ref_clk) keyRaw[idx] <= 1'b1;
        repeat (4) @(posedge ref_clk);
        keyRaw[idx] <= 1'b0;
        repeat (6) @(posedge ref_clk);
    endtask
    // the outside drives the local-select level; the mode follows it
    task automatic setTerms(input keypad_cmd_pkg::terminals_t t);
        @(posedge ref_clk) terminalRaw <= t;
        repeat (5) @(posedge ref_clk);
    endtask
endmodule // keypad_partner

// File: verification/keypad_command_selector_tb.sv
module keypad_command_selector_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [3:0] addr = '0;
    logic [31:0] wrData = '0;
    logic wrStrobe = 1'b0;
    logic rdStrobe = 1'b0;
    logic rdPend = 1'b0;
    logic [31:0] rdData;
    keypad_cmd_pkg::keys_t keyRaw;
    keypad_cmd_pkg::terminals_t terminalRaw;
    keypad_cmd_pkg::terminals_t t;
    keypad_cmd_pkg::keypad_mode_t keypadMode = keypad_cmd_pkg::MODE_RUNNING;
    logic [63:0] expQ[$];
    logic [63:0] e;
    logic [15:0] v, f, pidCmd, freqCmd;
    logic runFwd, runRev, showCmd, dp, locMode;
    logic linkFwd = 1'b0;
    logic linkRev = 1'b0;
    keypad_cmd_pkg::target_t keyTgt;
    int errorCnt = 0;
    int totalChecks = 0;
    int cycles = 0;
    int seed = 5;
    always #12.5 ref_clk = ~ref_clk;
    keypad_partner partner (.ref_clk(ref_clk), .keyRaw(keyRaw), .terminalRaw(terminalRaw));
    // short blink period keeps the run brief
    keypad_command_selector #(.BLINK_HALF_CYCLES(4)) dut (.ref_clk(ref_clk), .reset(reset),
        .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
        .rdData(rdData), .keyRaw(keyRaw), .terminalRaw(terminalRaw), .keypadMode(keypadMode),
        .linkRunForward(linkFwd), .linkRunReverse(linkRev), .runForward(runFwd),
        .runReverse(runRev), .pidCommand(pidCmd), .freqCommand(freqCmd), .keyTarget(keyTgt),
        .showPidCommand(showCmd), .decimalPoint(dp), .localMode(locMode));
    task automatic finishTest();
        $display("checks %0d errors %0d", totalChecks, errorCnt);
        if (errorCnt == 0 && totalChecks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] x);
        totalChecks++;
        if (seen !== x) begin
            errorCnt++;
            $display("wrong value %s expected %h seen %h", name, x, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        wrData <= d;
        wrStrobe <= 1'b1;
        @(posedge ref_clk);
        wrStrobe <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask
    // the expectation is noted before the strobe; the monitor compares it later
    task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] x);
        expQ.push_back({m, x});
        @(posedge ref_clk);
        addr <= a;
        rdStrobe <= 1'b1;
        @(posedge ref_clk);
        rdStrobe <= 1'b0;
        repeat (2) @(posedge ref_clk);
    endtask
    task automatic tgt(input keypad_cmd_pkg::target_t g);
        rd(keypad_cmd_pkg::ADDR_STATUS, 32'h000000e0, {24'h0, g, 5'h0});
    endtask
    function automatic logic [31:0] cfg(logic [4:0] mon, logic [1:0] rem, logic [1:0] pid);
        return {16'h0, 4'ha, keypad_cmd_pkg::FREQ_SRC_KEYPAD, mon, rem, pid};
    endfunction
    // read data stand only in the cycle after the strobe; a hang ends the run
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles > 2000) begin
            errorCnt++;
            finishTest();
        end
        if (rdPend) begin
            e = expQ.pop_front();
            check("rdData", rdData & e[63:32], e[31:0]);
        end
        rdPend <= rdStrobe;
    end
    initial begin
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        // multistep bit four stays on: keypad PID edits must still work
        t = terminalRaw;
        t.multistepBitFour = 1'b1;
        partner.setTerms(t);
        v = 16'($random(seed));
        f = 16'($random(seed));
        wr(keypad_cmd_pkg::ADDR_FREQ_CMD, {16'h0, f});
        wr(keypad_cmd_pkg::ADDR_PID_CMD, {16'h0, v});
        rd(keypad_cmd_pkg::ADDR_PID_CMD, 32'hffffffff, {16'h0, v});
        wr(keypad_cmd_pkg::ADDR_CONFIG, cfg(keypad_cmd_pkg::MON_PID_CMD, 2'h0, 2'h1));
        tgt(keypad_cmd_pkg::TGT_PID_CMD_EDIT);
        partner.press(3);
        if (v != 16'hffff) v = v + 16'h1;
        rd(keypad_cmd_pkg::ADDR_PID_CMD, 32'hffff, {16'h0, v});
        check("pidCommand", pidCmd, {16'h0, v});
        // non-running modes must leave the stored command alone
        for (int m = 0; m < 2; m++) begin
            keypadMode <= m ? keypad_cmd_pkg::MODE_ALARM : keypad_cmd_pkg::MODE_PROGRAMMING;
            partner.press(3);
            rd(keypad_cmd_pkg::ADDR_PID_CMD, 32'hffff, {16'h0, v});
        end
        keypadMode <= keypad_cmd_pkg::MODE_RUNNING;
        // remote PID source: keys only show the command, both PID selections
        for (int p = 1; p < 3; p++) begin
            wr(keypad_cmd_pkg::ADDR_CONFIG, cfg(keypad_cmd_pkg::MON_PID_FEEDBACK, 2'h1, 2'(p)));
            check("decimalPoint", dp, 1'b1);
            tgt(keypad_cmd_pkg::TGT_PID_CMD_VIEW);
            partner.press(2);
            check("showPidCommand", showCmd, 1'b1);
            rd(keypad_cmd_pkg::ADDR_PID_CMD, 32'hffff, {16'h0, v});
        end
        wr(keypad_cmd_pkg::ADDR_CONFIG, cfg(keypad_cmd_pkg::MON_SPEED, 2'h0, 2'h1));
        tgt(keypad_cmd_pkg::TGT_PID_OUTPUT);
        t = terminalRaw;
        t.pidBypass = 1'b1;
        partner.setTerms(t);
        tgt(keypad_cmd_pkg::TGT_FREQ_EDIT);
        partner.press(2);
        if (f != 16'h0) f = f - 16'h1;
        check("freqCommand", freqCmd, {16'h0, f});
        t.multistepBitOne = 1'b1;
        partner.setTerms(t);
        tgt(keypad_cmd_pkg::TGT_FREQ_VIEW);
        t.pidBypass = 1'b0;
        partner.setTerms(t);
        tgt(keypad_cmd_pkg::TGT_PID_OUTPUT);
        check("keyTarget", keyTgt, keypad_cmd_pkg::TGT_PID_OUTPUT);
        // run source 2 runs forward only, stop key returns to idle
        partner.press(1);
        rd(keypad_cmd_pkg::ADDR_STATUS, 32'hc, 32'h8);
        partner.press(0);
        rd(keypad_cmd_pkg::ADDR_STATUS, 32'hc, 32'h0);
        t.localModeSelect = 1'b1;
        partner.setTerms(t);
        rd(keypad_cmd_pkg::ADDR_STATUS, 32'h10, 32'h10);
        // local run key, then keypad removal stops the motor
        partner.press(1);
        check("runForward", runFwd, 1'b1);
        t.keypadPresent = 1'b0;
        partner.setTerms(t);
        check("runForward", runFwd, 1'b0);
        // back to remote with the link in charge of direction
        t.keypadPresent = 1'b1;
        t.localModeSelect = 1'b0;
        t.linkOperationSelect = 1'b1;
        linkRev <= 1'b1;
        partner.setTerms(t);
        check("runReverse", runRev, 1'b1);
        check("localMode", locMode, 1'b0);
        linkRev <= 1'b0;
        linkFwd <= 1'b1;
        repeat (2) @(posedge ref_clk);
        check("runForward", runFwd, 1'b1);
        finishTest();
    end
endmodule // keypad_command_selector_tb
